/* seepd_pkg.sv */
package seepd_pkg;
    // command codes, overridable per part
    localparam logic [7:0] OP_SET_WE = 8'h06;
    localparam logic [7:0] OP_SECT_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
    localparam logic [7:0] OP_DEEP_PD = 8'hb9;
    localparam logic [7:0] OP_RELEASE_SIG = 8'hab;
    // arbitrary value
    localparam logic [7:0] SIGNATURE_DEF = 8'h5a;
    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int T_ERASE_US = 15000;
    localparam int ERASE_CYC = T_ERASE_US * CYC_PER_US;
    localparam int POWERDOWN_SETTLE_NS = 3000;
    localparam int POWERDOWN_SETTLE_CYC = (POWERDOWN_SETTLE_NS * CYC_PER_US + 999) / 1000;
    localparam int RELEASE_DELAY_NS = 3000;
    localparam int RELEASE_DELAY_CYC = (RELEASE_DELAY_NS * CYC_PER_US + 999) / 1000;
    localparam int TMR_W = 18;
    localparam logic [TMR_W-1:0] TMR_ONE = 18'h00001;
    // frame layout
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
    localparam logic [CNT_W-1:0] OPC_BITS = 6'h08;
    localparam logic [CNT_W-1:0] HDR16_BITS = 6'h18;
    localparam logic [CNT_W-1:0] HDR24_BITS = 6'h20;
    localparam int ADDR_W = 24;
    localparam int SEC16_LSB = 14;
    localparam int SEC24_LSB = 15;
    // block protect codes
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [1:0] SECTOR_TOP = 2'h3;
    // synchroniser lanes
    localparam int SY_CS = 0;
    localparam int SY_SCK = 1;
    localparam int SY_SI = 2;
    localparam int SY_WP = 3;
    localparam logic [3:0] SYNC_RST = 4'h9;
    localparam logic [2:0] SIG_LAST = 3'h7;

    typedef enum logic [2:0] {
        PM_STANDBY = 3'b000,
        PM_ERASE = 3'b001,
        PM_SETTLE = 3'b010,
        PM_DEEP = 3'b011,
        PM_RELEASE = 3'b100
    } seepd_pm_t;
endpackage : seepd_pkg

/* seepd_ctrl.sv */
`timescale 1ns/1ps
module seepd_ctrl
#(
    parameter logic [7:0] OPC_SET_WE = seepd_pkg::OP_SET_WE,
    parameter logic [7:0] OPC_SE = seepd_pkg::OP_SECT_ERASE,
    parameter logic [7:0] OPC_CE = seepd_pkg::OP_CHIP_ERASE,
    parameter logic [7:0] OPC_DPD = seepd_pkg::OP_DEEP_PD,
    parameter logic [7:0] OPC_REL_SIG = seepd_pkg::OP_RELEASE_SIG,
    parameter logic [7:0] SIGNATURE = seepd_pkg::SIGNATURE_DEF,
    parameter int ERASE_CYCLES = seepd_pkg::ERASE_CYC
)
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // spi pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    output logic so_r,
    output logic so_oe_n_r,
    // status register side
    input wire logic block_protect_lo,
    input wire logic block_protect_hi,
    input wire logic protect_pin_enable,
    input wire logic low_density,
    input wire logic addr_24bit,
    input wire logic ext_busy,
    input wire logic we_latch_clear,
    output logic write_enable_latch_r,
    output logic write_busy_flag_r,
    output logic status_nv_lock_r,
    // array erase requests
    output logic erase_chip_go_r,
    output logic erase_sector_go_r,
    output logic [1:0] erase_sector_r,
    // power state
    output logic deep_powerdown_r,
    output logic lowest_power_r
);
    import seepd_pkg::*;

    localparam logic [TMR_W-1:0] ERASE_T = TMR_W'(ERASE_CYCLES);
    localparam logic [TMR_W-1:0] SETTLE_T = TMR_W'(POWERDOWN_SETTLE_CYC);
    localparam logic [TMR_W-1:0] RELEASE_T = TMR_W'(RELEASE_DELAY_CYC);

    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic sck_d_r;
    logic cs_d_r;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic wp_low;
    logic [1:0] bp;

    // pin synchronisers, second stage only is read
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end
        else if (clk_en)
        begin
            s1_r <= {wp_n, si, sck, cs_n};
            s2_r <= s1_r;
            sck_d_r <= s2_r[SY_SCK];
            cs_d_r <= s2_r[SY_CS];
        end
    end

    always_comb
    begin
        sck_rise = s2_r[SY_SCK] & ~sck_d_r;
        sck_fall = ~s2_r[SY_SCK] & sck_d_r;
        cs_rise = s2_r[SY_CS] & ~cs_d_r;
        cs_fall = ~s2_r[SY_CS] & cs_d_r;
        wp_low = ~s2_r[SY_WP];
        bp = {block_protect_hi, block_protect_lo};
    end

    seepd_pm_t pm_r;
    seepd_pm_t pm_nxt;
    logic sel_r;
    logic sel_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [7:0] op_r;
    logic [7:0] op_nxt;
    logic [ADDR_W-1:0] sh_r;
    logic [ADDR_W-1:0] sh_nxt;
    logic [2:0] sig_idx_r;
    logic [2:0] sig_idx_nxt;
    logic [TMR_W-1:0] tmr_r;
    logic [TMR_W-1:0] tmr_nxt;
    logic so_nxt;
    logic so_oe_n_nxt;
    logic latch_nxt;
    logic ce_go_nxt;
    logic se_go_nxt;
    logic [1:0] sector_nxt;
    logic [CNT_W-1:0] hdr_len;
    logic [1:0] sector;
    logic sec_prot;
    logic in_dpd;
    logic busy_any;
    logic prog_ok;

    always_comb
    begin
        pm_nxt = pm_r;
        sel_nxt = sel_r;
        cnt_nxt = cnt_r;
        op_nxt = op_r;
        sh_nxt = sh_r;
        sig_idx_nxt = sig_idx_r;
        tmr_nxt = tmr_r;
        so_nxt = so_r;
        so_oe_n_nxt = so_oe_n_r;
        latch_nxt = write_enable_latch_r;
        ce_go_nxt = 1'b0;
        se_go_nxt = 1'b0;
        sector_nxt = erase_sector_r;
        hdr_len = addr_24bit ? HDR24_BITS : HDR16_BITS;
        sector = addr_24bit ? sh_r[SEC24_LSB +: 2] : sh_r[SEC16_LSB +: 2];
        // protected sectors per protect code
        sec_prot = (bp == BP_ALL) || (bp == BP_HALF && sector[1])
            || (bp == BP_QUARTER && sector == SECTOR_TOP);
        in_dpd = (pm_r == PM_SETTLE) || (pm_r == PM_DEEP);
        busy_any = (pm_r == PM_ERASE) || ext_busy;
        prog_ok = ~(low_density & wp_low);
        if (pm_r == PM_ERASE || pm_r == PM_SETTLE || pm_r == PM_RELEASE)
        begin
            tmr_nxt = tmr_r - TMR_ONE;
            if (tmr_r == TMR_ONE)
                pm_nxt = (pm_r == PM_SETTLE) ? PM_DEEP : PM_STANDBY;
        end
        // frame starts only on a select fall
        if (cs_fall)
        begin
            sel_nxt = 1'b1;
            cnt_nxt = '0;
            sig_idx_nxt = '0;
        end
        if (sel_r && sck_rise)
        begin
            if (cnt_r != CNT_MAX)
                cnt_nxt = cnt_r + 1'b1;
            if (cnt_r < OPC_BITS)
                op_nxt = {op_r[6:0], s2_r[SY_SI]};
            else
                sh_nxt = {sh_r[ADDR_W-2:0], s2_r[SY_SI]};
        end
        // signature out after the dummy address, repeating
        if (sel_r && sck_fall && op_r == OPC_REL_SIG && cnt_r >= hdr_len && !busy_any)
        begin
            so_nxt = SIGNATURE[SIG_LAST - sig_idx_r];
            so_oe_n_nxt = 1'b0;
            sig_idx_nxt = sig_idx_r + 1'b1;
        end
        if (cs_rise)
        begin
            sel_nxt = 1'b0;
            so_oe_n_nxt = 1'b1;
            if (sel_r && in_dpd)
            begin
                // only the release command is heard here
                if (op_r == OPC_REL_SIG && cnt_r >= OPC_BITS)
                begin
                    pm_nxt = PM_RELEASE;
                    tmr_nxt = RELEASE_T;
                end
            end
            else if (sel_r && pm_r == PM_STANDBY && !ext_busy)
            begin
                if (op_r == OPC_SET_WE && cnt_r == OPC_BITS && prog_ok)
                    latch_nxt = 1'b1;
                else if (op_r == OPC_CE && cnt_r == OPC_BITS && write_enable_latch_r
                    && prog_ok && bp == BP_NONE)
                begin
                    pm_nxt = PM_ERASE;
                    tmr_nxt = ERASE_T;
                    ce_go_nxt = 1'b1;
                    latch_nxt = 1'b0;
                end
                else if (op_r == OPC_SE && cnt_r == hdr_len && write_enable_latch_r
                    && prog_ok && !sec_prot)
                begin
                    pm_nxt = PM_ERASE;
                    tmr_nxt = ERASE_T;
                    se_go_nxt = 1'b1;
                    sector_nxt = sector;
                    latch_nxt = 1'b0;
                end
                else if (op_r == OPC_DPD && cnt_r == OPC_BITS)
                begin
                    pm_nxt = PM_SETTLE;
                    tmr_nxt = SETTLE_T;
                end
            end
        end
        // frame set of the latch wins over a software clear
        if (we_latch_clear && !(latch_nxt && !write_enable_latch_r))
            latch_nxt = 1'b0;
        if (!prog_ok)
            latch_nxt = 1'b0;
    end

    // power-up: standby, latch clear, output floating
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pm_r <= PM_STANDBY;
            sel_r <= 1'b0;
            cnt_r <= '0;
            op_r <= '0;
            sh_r <= '0;
            sig_idx_r <= '0;
            tmr_r <= '0;
            so_r <= 1'b0;
            so_oe_n_r <= 1'b1;
            write_enable_latch_r <= 1'b0;
            write_busy_flag_r <= 1'b0;
            status_nv_lock_r <= 1'b0;
            erase_chip_go_r <= 1'b0;
            erase_sector_go_r <= 1'b0;
            erase_sector_r <= '0;
            deep_powerdown_r <= 1'b0;
            lowest_power_r <= 1'b0;
        end
        else if (clk_en)
        begin
            pm_r <= pm_nxt;
            sel_r <= sel_nxt;
            cnt_r <= cnt_nxt;
            op_r <= op_nxt;
            sh_r <= sh_nxt;
            sig_idx_r <= sig_idx_nxt;
            tmr_r <= tmr_nxt;
            so_r <= so_nxt;
            so_oe_n_r <= so_oe_n_nxt;
            write_enable_latch_r <= latch_nxt;
            write_busy_flag_r <= (pm_nxt == PM_ERASE) || ext_busy;
            status_nv_lock_r <= ~low_density & protect_pin_enable & wp_low;
            erase_chip_go_r <= ce_go_nxt;
            erase_sector_go_r <= se_go_nxt;
            erase_sector_r <= sector_nxt;
            deep_powerdown_r <= (pm_nxt == PM_SETTLE) || (pm_nxt == PM_DEEP);
            lowest_power_r <= (pm_nxt == PM_DEEP);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_ce_unprotected;
        clk_en && erase_chip_go_r |-> $past(bp) == BP_NONE;
    endproperty
    a_ce_unprotected: assert property (p_ce_unprotected)
        else $error("chip erase started with protect bits set");
    property p_erase_busy;
        clk_en && (erase_chip_go_r || erase_sector_go_r) |-> write_busy_flag_r;
    endproperty
    a_erase_busy: assert property (p_erase_busy)
        else $error("erase started without busy flag");
    property p_se_on_cs_rise;
        clk_en && erase_sector_go_r |-> $past(cs_rise) && $past(cnt_r) == $past(hdr_len);
    endproperty
    a_se_on_cs_rise: assert property (p_se_on_cs_rise)
        else $error("sector erase not started by select rise after address");
    property p_se_unprotected;
        clk_en && erase_sector_go_r |-> !$past(sec_prot);
    endproperty
    a_se_unprotected: assert property (p_se_unprotected)
        else $error("protected sector erased");
    property p_deep_no_erase;
        clk_en && $past(pm_r) == PM_DEEP |-> !erase_chip_go_r && !erase_sector_go_r;
    endproperty
    a_deep_no_erase: assert property (p_deep_no_erase)
        else $error("erase accepted in deep power-down");
    property p_low_after_settle;
        clk_en && $rose(lowest_power_r) |-> $past(pm_r) == PM_SETTLE && $past(tmr_r) == TMR_ONE;
    endproperty
    a_low_after_settle: assert property (p_low_after_settle)
        else $error("lowest power reached before settling delay");
    property p_float_on_deselect;
        clk_en && cs_rise ##1 clk_en |-> so_oe_n_r;
    endproperty
    a_float_on_deselect: assert property (p_float_on_deselect)
        else $error("output driven after deselect");
    property p_wp_clears_latch;
        clk_en && low_density && wp_low ##1 clk_en |-> !write_enable_latch_r;
    endproperty
    a_wp_clears_latch: assert property (p_wp_clears_latch)
        else $error("write latch kept with protect pin low");
    property p_so_after_fall;
        clk_en && $changed(so_r) |-> $past(sck_fall);
    endproperty
    a_so_after_fall: assert property (p_so_after_fall)
        else $error("output changed without clock fall");
endmodule : seepd_ctrl

/* seepd_host.sv */
`timescale 1ns/1ps
module seepd_host
(
    // clock
    input wire logic sys_clk,
    // spi pins
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so_r,
    input wire logic so_oe_n_r
);
    logic [15:0] rd_r;

    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        rd_r = 16'h0000;
    end

    // half of the 800 ns link period
    task automatic half;
        repeat (4) @(negedge sys_clk);
    endtask : half

    // mode 0 frame: n bits out msb first, then m bits read back
    task automatic frame(input logic [31:0] d, input int n, input int m);
        @(negedge sys_clk);
        cs_n = 1'b0;
        half();
        for (int i = 0; i < n + m; i++)
        begin
            // unused input toggles so a stale level is never trusted
            si = (i < n) ? d[31 - i] : ~si;
            half();
            sck = 1'b1;
            if (i >= n)
            begin
                // a floating output reads as the inverse of the last driven bit
                rd_r = {rd_r[14:0], so_oe_n_r ? ~so_r : so_r};
            end
            half();
            sck = 1'b0;
        end
        half();
        cs_n = 1'b1;
        si = ~si;
        half();
    endtask : frame
endmodule : seepd_host

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import seepd_pkg::*;
    localparam int ERASE_N = 50;
    logic sys_clk = 1'b0;
    logic rst, clk_en, wp_n, bp_lo, bp_hi, pin_en, low_den, a24, ext_busy, latch_clr;
    logic cs_n, sck, si, so_r, so_oe_n_r, we_latch, busy, lock, ce_go, se_go, deep, lowest;
    logic [1:0] sec, last_sec;
    int err_total = 0;
    int comparisons = 0;
    int ce_cnt = 0;
    int se_cnt = 0;
    int cyc = 0;

    always #50 sys_clk = ~sys_clk;

    seepd_ctrl #(.ERASE_CYCLES(ERASE_N)) dut (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
        .so_r(so_r), .so_oe_n_r(so_oe_n_r),
        .block_protect_lo(bp_lo), .block_protect_hi(bp_hi),
        .protect_pin_enable(pin_en), .low_density(low_den),
        .addr_24bit(a24), .ext_busy(ext_busy), .we_latch_clear(latch_clr),
        .write_enable_latch_r(we_latch), .write_busy_flag_r(busy),
        .status_nv_lock_r(lock), .erase_chip_go_r(ce_go),
        .erase_sector_go_r(se_go), .erase_sector_r(sec),
        .deep_powerdown_r(deep), .lowest_power_r(lowest)
    );

    seepd_host host (
        .sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si),
        .so_r(so_r), .so_oe_n_r(so_oe_n_r)
    );

    always @(posedge sys_clk)
    begin
        if (ce_go === 1'b1) ce_cnt++;
        if (se_go === 1'b1)
        begin
            se_cnt++;
            last_sec = sec;
        end
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic gap(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : gap

    task automatic set_we;
        host.frame({OP_SET_WE, 24'h000000}, 8, 0);
    endtask : set_we

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    initial
    begin
        {rst, clk_en, wp_n} = 3'h7;
        {bp_lo, bp_hi, pin_en, low_den, a24, ext_busy, latch_clr} = 7'h00;
        last_sec = 2'h0;
        gap(4);
        rst = 1'b0;
        gap(4);
        chk(so_oe_n_r, 1'b1);
        chk({we_latch, busy, deep, lowest, ce_go, se_go}, 6'h00);
        $display("test reset done");
        bp_lo = 1'b1;
        set_we();
        chk(we_latch, 1'b1);
        host.frame({OP_CHIP_ERASE, 24'h000000}, 8, 0);
        gap(4);
        chk(ce_cnt, 0);
        bp_lo = 1'b0;
        host.frame({OP_CHIP_ERASE, 24'h000000}, 9, 0);
        gap(4);
        chk(ce_cnt, 0);
        host.frame({OP_CHIP_ERASE, 24'h000000}, 8, 0);
        gap(3);
        chk(ce_cnt, 1);
        chk(busy, 1'b1);
        chk(we_latch, 1'b0);
        gap(ERASE_N + 10);
        chk(busy, 1'b0);
        $display("test chip erase done");
        set_we();
        host.frame({OP_SECT_ERASE, 16'hc123, 8'h00}, 24, 0);
        gap(3);
        chk(se_cnt, 1);
        chk(last_sec, 2'h3);
        gap(ERASE_N + 10);
        bp_lo = 1'b1;
        set_we();
        host.frame({OP_SECT_ERASE, 16'hc000, 8'h00}, 24, 0);
        gap(4);
        chk(se_cnt, 1);
        a24 = 1'b1;
        host.frame({OP_SECT_ERASE, 24'h010000}, 32, 0);
        gap(3);
        chk(se_cnt, 2);
        chk(last_sec, 2'h2);
        gap(ERASE_N + 10);
        {bp_lo, a24} = 2'h0;
        $display("test sector erase done");
        host.frame({OP_DEEP_PD, 24'h000000}, 8, 0);
        gap(3);
        chk({deep, lowest}, 2'h2);
        gap(40);
        chk(lowest, 1'b1);
        set_we();
        chk(we_latch, 1'b0);
        host.frame({OP_RELEASE_SIG, 24'h000000}, 8, 0);
        gap(3);
        chk(deep, 1'b0);
        gap(40);
        host.frame({OP_DEEP_PD, 24'h000000}, 8, 0);
        gap(40);
        host.frame({OP_RELEASE_SIG, 24'h000000}, 24, 16);
        chk(host.rd_r, {SIGNATURE_DEF, SIGNATURE_DEF});
        chk({deep, so_oe_n_r}, 2'h1);
        gap(40);
        a24 = 1'b1;
        host.frame({OP_RELEASE_SIG, 24'h000000}, 32, 8);
        chk(host.rd_r[7:0], SIGNATURE_DEF);
        a24 = 1'b0;
        gap(40);
        host.frame({OP_DEEP_PD, 24'h000000}, 8, 0);
        gap(40);
        chk(lowest, 1'b1);
        rst = 1'b1;
        gap(2);
        rst = 1'b0;
        gap(4);
        chk({deep, lowest, so_oe_n_r}, 3'h1);
        $display("test power down done");
        low_den = 1'b1;
        set_we();
        chk(we_latch, 1'b1);
        wp_n = 1'b0;
        gap(6);
        chk(we_latch, 1'b0);
        {wp_n, low_den, pin_en} = 3'h5;
        gap(6);
        chk(lock, 1'b0);
        wp_n = 1'b0;
        gap(6);
        chk(lock, 1'b1);
        pin_en = 1'b0;
        gap(6);
        chk(lock, 1'b0);
        wp_n = 1'b1;
        set_we();
        chk(we_latch, 1'b1);
        latch_clr = 1'b1;
        gap(1);
        latch_clr = 1'b0;
        gap(2);
        chk(we_latch, 1'b0);
        ext_busy = 1'b1;
        gap(3);
        chk(busy, 1'b1);
        ext_busy = 1'b0;
        gap(3);
        chk(busy, 1'b0);
        $display("test protect pin done");
        stop_test();
    end
endmodule : tb_top
